/* File: include/gpt_pkg.sv */
/*
 * package for the general purpose timer: widths, modes, carrier structs.
 * assumes a single timer clock and a synchronous active-high reset.
 */
package gpt_pkg;
  localparam int GPT_PSC_W = 16;
  localparam int GPT_NCH = 4;
  localparam int GPT_SYNC_DEPTH = 3;
  localparam logic [15:0] GPT_PSC_RST = 16'h0000;
  localparam logic [31:0] GPT_ARR_RST = 32'hffff_ffff;
  localparam logic [31:0] GPT_CCR_RST = 32'h0000_0000;
  localparam logic [31:0] GPT_CNT_RST = 32'h0000_0000;

  typedef enum logic [2:0] {
    GPT_CH_OFF,
    GPT_CH_CAPTURE,
    GPT_CH_COMPARE,
    GPT_CH_PWM,
    GPT_CH_ONEPULSE
  } gpt_chmode_e;

  typedef enum logic [1:0] {
    GPT_SRC_INT,
    GPT_SRC_ENCODER,
    GPT_SRC_HALL,
    GPT_SRC_EXTTRIG
  } gpt_src_e;

  // per-channel configuration
  typedef struct packed {
    gpt_chmode_e mode;
    logic cap_fall;
    logic dma_en;
    logic [31:0] cmp;
  } gpt_chcfg_s;

  // timebase configuration
  typedef struct packed {
    logic enable;
    logic down;
    logic wide;
    logic dbg_freeze;
    logic upd_dma_en;
    gpt_src_e src;
    logic [15:0] psc;
    logic [31:0] arr;
  } gpt_tbcfg_s;
endpackage

/* File: rtl/gpt_sync.sv */
/*
 * three-stage input synchroniser with agreement of stages two and three.
 * assumes the input is asynchronous to mclk.
 */
`timescale 1ns/10ps
module gpt_sync
  import gpt_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // data
  input wire logic din,
  output logic dout
);
  logic [2:0] st_reg;
  logic [2:0] st_next;
  logic out_reg;
  logic out_next;

  always_comb begin
    st_next = {st_reg[1:0], din};
    out_next = (st_reg[1] == st_reg[2]) ? st_reg[2] : out_reg;
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      st_reg <= 3'h0;
      out_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      out_reg <= out_next;
    end
  end

  assign dout = out_reg;
endmodule

/* File: rtl/gpt_timer.sv */
/*
 * general purpose timer: prescaler, up/down auto-reload counter, four channels,
 * encoder and hall inputs, timer link, dma requests and debug freeze.
 * assumes configuration is held steady by the surrounding logic.
 */
// Contract
// - wide instance: 32-bit counter, 16-bit prescaler
// - narrow instance: 16-bit counter, same prescaler
// - four channels: capture, compare, pwm, one-pulse
// - own dma request lines
// - quadrature encoder counts position
// - one to four hall sensor inputs
// - trigger in/out links to other timers
// - debug halt freezes counter, except that a hall change still resets it in hall mode
`timescale 1ns/10ps
module gpt_timer
  import gpt_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // configuration
  input wire gpt_tbcfg_s tb_cfg,
  input wire gpt_chcfg_s [GPT_NCH-1:0] ch_cfg,
  input wire logic [GPT_NCH-1:0] flag_clr,
  // pins and links
  input wire logic [GPT_NCH-1:0] ch_in,
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic [3:0] hall_in,
  input wire logic [3:0] hall_en,
  input wire logic trig_in,
  input wire logic dbg_halt,
  // results
  output logic [GPT_NCH-1:0] ch_out,
  output logic [31:0] cnt,
  output logic [GPT_NCH-1:0] ch_flag,
  output logic upd_flag,
  output logic [GPT_NCH-1:0] ch_dma_req,
  output logic upd_dma_req,
  output logic trig_out,
  output logic [31:0] cap_val [GPT_NCH]
);
  // ************
  // input synchronisers
  // ************
  logic [GPT_NCH+6:0] raw;
  logic [GPT_NCH+6:0] syn;
  assign raw = {trig_in, enc_a, enc_b, hall_in, ch_in};

  genvar gi;
  generate
    for (gi = 0; gi < GPT_NCH + 7; gi++) begin : g_sync
      gpt_sync u_sync (
        .mclk(mclk),
        .srst(srst),
        .din(raw[gi]),
        .dout(syn[gi])
      );
    end
  endgenerate

  logic [GPT_NCH-1:0] chs;
  logic [3:0] halls;
  logic enc_as;
  logic enc_bs;
  logic trigs;
  assign chs = syn[GPT_NCH-1:0];
  assign halls = syn[GPT_NCH+3:GPT_NCH] & hall_en;
  assign enc_bs = syn[GPT_NCH+4];
  assign enc_as = syn[GPT_NCH+5];
  assign trigs = syn[GPT_NCH+6];

  // ************
  // timebase
  // ************
  logic [15:0] psc_reg, psc_next;
  logic [31:0] cnt_reg, cnt_next;
  logic [31:0] top;
  logic upd_reg, upd_next;
  logic updp_reg, updp_next;
  logic updd_reg, updd_next;
  logic enca_reg, enca_next;
  logic encb_reg, encb_next;
  logic [3:0] hall_reg, hall_next;
  logic trg_reg, trg_next;
  logic tick;
  logic step;
  logic dir_down;
  logic enc_step;

  // narrow instance clips the reload value to 16 bits
  assign top = tb_cfg.wide ? tb_cfg.arr : {16'h0000, tb_cfg.arr[15:0]};

  always_comb begin
    psc_next = psc_reg;
    cnt_next = cnt_reg;
    upd_next = upd_reg;
    updp_next = 1'b0;
    enca_next = enc_as;
    encb_next = enc_bs;
    hall_next = halls;
    trg_next = trigs;
    tick = 1'b0;
    step = 1'b0;
    dir_down = tb_cfg.down;
    enc_step = (enc_as ^ enca_reg) | (enc_bs ^ encb_reg);
    if (tb_cfg.enable && !(tb_cfg.dbg_freeze && dbg_halt)) begin
      if (psc_reg >= tb_cfg.psc) begin
        psc_next = GPT_PSC_RST;
        tick = 1'b1;
      end else begin
        psc_next = psc_reg + 16'h0001;
      end
    end
    unique case (tb_cfg.src)
      GPT_SRC_INT: step = tick;
      GPT_SRC_ENCODER: begin
        // x4 decoding, direction from phase relation
        step = enc_step && tb_cfg.enable && !(tb_cfg.dbg_freeze && dbg_halt);
        dir_down = (enc_as ^ encb_reg);
      end
      GPT_SRC_HALL: step = tick && (halls == hall_reg);
      GPT_SRC_EXTTRIG: step = tick && trigs && !trg_reg;
    endcase
    if (step) begin
      if (dir_down) begin
        if (cnt_reg == 32'h0000_0000) begin
          cnt_next = top;
          updp_next = 1'b1;
        end else begin
          cnt_next = cnt_reg - 32'h0000_0001;
        end
      end else begin
        if (cnt_reg >= top) begin
          cnt_next = GPT_CNT_RST;
          updp_next = 1'b1;
        end else begin
          cnt_next = cnt_reg + 32'h0000_0001;
        end
      end
    end
    // hall commutation resets the count and flags an update
    if (tb_cfg.src == GPT_SRC_HALL && halls != hall_reg) begin
      cnt_next = GPT_CNT_RST;
      updp_next = 1'b1;
    end
    if (flag_clr == {GPT_NCH{1'b1}}) begin
      upd_next = 1'b0;
    end
    if (updp_next) begin
      upd_next = 1'b1;
    end
    updd_next = updp_next & tb_cfg.upd_dma_en;
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      psc_reg <= GPT_PSC_RST;
      cnt_reg <= GPT_CNT_RST;
      upd_reg <= 1'b0;
      updp_reg <= 1'b0;
      updd_reg <= 1'b0;
      enca_reg <= 1'b0;
      encb_reg <= 1'b0;
      hall_reg <= 4'h0;
      trg_reg <= 1'b0;
    end else begin
      psc_reg <= psc_next;
      cnt_reg <= cnt_next;
      upd_reg <= upd_next;
      updp_reg <= updp_next;
      updd_reg <= updd_next;
      enca_reg <= enca_next;
      encb_reg <= encb_next;
      hall_reg <= hall_next;
      trg_reg <= trg_next;
    end
  end

  // ************
  // channels
  // ************
  logic [GPT_NCH-1:0] chin_reg, chin_next;
  logic [GPT_NCH-1:0] flag_reg, flag_next;
  logic [GPT_NCH-1:0] out_reg, out_next;
  logic [GPT_NCH-1:0] dreq_reg, dreq_next;
  logic [GPT_NCH-1:0] done_reg, done_next;
  logic [31:0] cap_reg [GPT_NCH];
  logic [31:0] cap_next [GPT_NCH];

  generate
    for (gi = 0; gi < GPT_NCH; gi++) begin : g_ch
      logic edge_hit;
      logic match;
      assign edge_hit = ch_cfg[gi].cap_fall ? (chin_reg[gi] & ~chs[gi]) : (~chin_reg[gi] & chs[gi]);
      assign match = step && (cnt_next == ch_cfg[gi].cmp);
      always_comb begin
        chin_next[gi] = chs[gi];
        cap_next[gi] = cap_reg[gi];
        out_next[gi] = out_reg[gi];
        done_next[gi] = done_reg[gi];
        flag_next[gi] = flag_reg[gi] & ~flag_clr[gi];
        dreq_next[gi] = 1'b0;
        unique case (ch_cfg[gi].mode)
          GPT_CH_OFF: out_next[gi] = 1'b0;
          GPT_CH_CAPTURE: begin
            if (edge_hit) begin
              cap_next[gi] = cnt_reg;
              flag_next[gi] = 1'b1;
              dreq_next[gi] = ch_cfg[gi].dma_en;
            end
          end
          GPT_CH_COMPARE: begin
            if (match) begin
              out_next[gi] = ~out_reg[gi];
              flag_next[gi] = 1'b1;
              dreq_next[gi] = ch_cfg[gi].dma_en;
            end
          end
          GPT_CH_PWM: out_next[gi] = (cnt_next < ch_cfg[gi].cmp);
          GPT_CH_ONEPULSE: begin
            // single pulse from compare to reload, then parked
            if (match && !done_reg[gi]) begin
              out_next[gi] = 1'b1;
              flag_next[gi] = 1'b1;
            end
            if (updp_next && out_reg[gi]) begin
              out_next[gi] = 1'b0;
              done_next[gi] = 1'b1;
            end
          end
          default: out_next[gi] = 1'b0;
        endcase
        if (ch_cfg[gi].mode != GPT_CH_ONEPULSE) begin
          done_next[gi] = 1'b0;
        end
      end
      always_ff @(posedge mclk) begin
        if (srst) begin
          cap_reg[gi] <= GPT_CCR_RST;
        end else begin
          cap_reg[gi] <= cap_next[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk) begin
    if (srst) begin
      chin_reg <= '0;
      flag_reg <= '0;
      out_reg <= '0;
      dreq_reg <= '0;
      done_reg <= '0;
    end else begin
      chin_reg <= chin_next;
      flag_reg <= flag_next;
      out_reg <= out_next;
      dreq_reg <= dreq_next;
      done_reg <= done_next;
    end
  end

  // ************
  // outputs
  // ************
  assign cnt = cnt_reg;
  assign ch_out = out_reg;
  assign ch_flag = flag_reg;
  assign ch_dma_req = dreq_reg;
  assign upd_flag = upd_reg;
  assign upd_dma_req = updd_reg;
  assign trig_out = updp_reg;
  assign cap_val = cap_reg;

  // ************
  // assertions
  // ************
  a_freeze_holds: assert property (@(posedge mclk) disable iff (srst)
    (tb_cfg.dbg_freeze && dbg_halt && tb_cfg.src == GPT_SRC_INT) |=> $stable(cnt_reg))
    else $error("counter moved while frozen");
  a_narrow_range: assert property (@(posedge mclk) disable iff (srst)
    (!tb_cfg.wide && $stable(tb_cfg) && cnt_reg[31:16] == 16'h0000) |=> cnt_reg[31:16] == 16'h0000)
    else $error("narrow counter exceeded 16 bits");
  a_wrap_reload: assert property (@(posedge mclk) disable iff (srst)
    (step && !dir_down && cnt_reg >= top && tb_cfg.src != GPT_SRC_HALL) |=> cnt_reg == 32'h0 && updp_reg)
    else $error("overflow did not reload");
  a_under_reload: assert property (@(posedge mclk) disable iff (srst)
    (step && dir_down && cnt_reg == 32'h0 && tb_cfg.src != GPT_SRC_HALL) |=> cnt_reg == $past(top))
    else $error("underflow did not reload");
  a_upd_sticky: assert property (@(posedge mclk) disable iff (srst)
    (upd_reg && flag_clr != 4'hf) |=> upd_reg)
    else $error("update flag dropped without clear");
  a_cap_latch: assert property (@(posedge mclk) disable iff (srst)
    (ch_cfg[0].mode == GPT_CH_CAPTURE && g_ch[0].edge_hit) |=> cap_reg[0] == $past(cnt_reg) && flag_reg[0])
    else $error("capture not latched");
  a_cap_dma: assert property (@(posedge mclk) disable iff (srst)
    dreq_reg[0] |-> $past(ch_cfg[0].dma_en))
    else $error("dma request without enable");
  a_trig_link: assert property (@(posedge mclk) disable iff (srst)
    (tb_cfg.src == GPT_SRC_EXTTRIG && !(trigs && !trg_reg)) |=> $stable(cnt_reg))
    else $error("count moved without trigger edge");
  a_pwm_level: assert property (@(posedge mclk) disable iff (srst)
    (ch_cfg[2].mode == GPT_CH_PWM && $stable(ch_cfg[2])) |=> ch_out[2] == (cnt_reg < ch_cfg[2].cmp))
    else $error("pwm level wrong");
  a_enc_idle: assert property (@(posedge mclk) disable iff (srst)
    (tb_cfg.src == GPT_SRC_ENCODER && !enc_step) |=> $stable(cnt_reg))
    else $error("encoder count moved without edge");
  a_hall_reset: assert property (@(posedge mclk) disable iff (srst)
    (tb_cfg.src == GPT_SRC_HALL && halls != hall_reg) |=> cnt_reg == 32'h0)
    else $error("hall change did not restart count");

  c_overflow: cover property (@(posedge mclk) updp_reg && !tb_cfg.down);
  c_capture: cover property (@(posedge mclk) flag_reg[0] && ch_cfg[0].mode == GPT_CH_CAPTURE);
  c_onepulse: cover property (@(posedge mclk) done_reg[3]);
  c_freeze: cover property (@(posedge mclk) dbg_halt && tb_cfg.dbg_freeze && tb_cfg.enable);
endmodule

/* File: tb/gpt_partner.sv */
/*
 * far-side model: quadrature encoder and hall sensors on the timer pins.
 * assumes mclk is the timer clock; each level is held long enough for the synchronisers.
 */
`timescale 1ns/10ps
module gpt_partner
  import gpt_pkg::*;
(
  // clock
  input wire logic mclk,
  // pins
  output logic enc_a,
  output logic enc_b,
  output logic [3:0] hall_in
);
  logic [1:0] ph_reg = 2'h0;
  initial hall_in = 4'h0;
  // gray sequence 00,01,11,10 when moving forward
  assign enc_a = ph_reg[1];
  assign enc_b = ph_reg[1] ^ ph_reg[0];
  task automatic enc_move(input int n, input logic dn);
    repeat (n) begin
      @(posedge mclk);
      ph_reg <= dn ? ph_reg - 2'h1 : ph_reg + 2'h1;
      repeat (6) @(posedge mclk);
    end
  endtask
  task automatic hall_set(input logic [3:0] v);
    @(posedge mclk);
    hall_in <= v;
  endtask
endmodule

/* File: tb/tb.sv */
/*
 * self-checking bench for the general purpose timer.
 * assumes the partner model drives encoder and hall pins; bench drives the rest.
 */
`timescale 1ns/10ps
module tb
  import gpt_pkg::*;
;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  gpt_tbcfg_s tb_cfg = '0;
  gpt_chcfg_s [GPT_NCH-1:0] ch_cfg = '0;
  logic [3:0] flag_clr = 4'h0, ch_in = 4'h0, hall_in, hall_en = 4'h0, ch_out, ch_flag, ch_dma_req;
  logic enc_a, enc_b, trig_in = 1'b0, dbg_halt = 1'b0, upd_flag, upd_dma_req, trig_out;
  logic [31:0] cnt;
  logic [31:0] cap_val [GPT_NCH];
  int errors = 0;
  int checks = 0;

  gpt_timer dut_u (.mclk(mclk), .srst(srst), .tb_cfg(tb_cfg), .ch_cfg(ch_cfg), .flag_clr(flag_clr),
    .ch_in(ch_in), .enc_a(enc_a), .enc_b(enc_b), .hall_in(hall_in), .hall_en(hall_en), .trig_in(trig_in),
    .dbg_halt(dbg_halt), .ch_out(ch_out), .cnt(cnt), .ch_flag(ch_flag),
    .upd_flag(upd_flag), .ch_dma_req(ch_dma_req), .upd_dma_req(upd_dma_req), .trig_out(trig_out),
    .cap_val(cap_val));
  gpt_partner pm_u (.mclk(mclk), .enc_a(enc_a), .enc_b(enc_b), .hall_in(hall_in));

  initial begin
    forever #5 mclk = ~mclk;
  end

  // ****************
  // helpers
  // ****************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chkb(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge mclk);
      #1;
    end
  endtask
  // restart the counter from zero, then apply the timebase
  task automatic setup(input logic dn, input logic wd, input gpt_src_e src, input logic [15:0] psc,
                       input logic [31:0] arr);
    @(posedge mclk);
    srst <= 1'b1;
    tb_cfg <= '0;
    @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    tb_cfg <= '{1'b1, dn, wd, 1'b0, 1'b1, src, psc, arr};
  endtask
  task automatic wait_cnt(input logic [31:0] v);
    for (int i = 0; i < 60 && cnt !== v; i++) tick(1);
    chk(cnt, v);
  endtask
  task automatic close_out;
    if (errors == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ****************
  // scenarios
  // ****************
  task automatic t_count;
    logic [31:0] v;
    setup(1'b0, 1'b1, GPT_SRC_INT, 16'h0, 32'h2);
    wait_cnt(32'h1);
    tick(1);
    chk(cnt, 32'h2);
    tick(1);
    chk(cnt, 32'h0);
    chk({trig_out, upd_flag, upd_dma_req}, 32'h7);
    tick(1);
    chk({trig_out, upd_flag, upd_dma_req}, 32'h2);
    // clear lands on the wrap edge: set wins
    @(posedge mclk);
    flag_clr <= 4'hf;
    @(posedge mclk);
    flag_clr <= 4'h0;
    tick(2);
    chkb(upd_flag, 1'b1);
    @(posedge mclk);
    flag_clr <= 4'hf;
    @(posedge mclk);
    flag_clr <= 4'h0;
    tick(1);
    chkb(upd_flag, 1'b0);
    setup(1'b1, 1'b0, GPT_SRC_INT, 16'h0, 32'h3_0002);
    wait_cnt(32'h2);
    tick(2);
    chk(cnt, 32'h0);
    tick(1);
    chk(cnt, 32'h2);
    setup(1'b0, 1'b1, GPT_SRC_INT, 16'h0, 32'h1_0002);
    wait_cnt(32'h2);
    tick(1);
    chk(cnt, 32'h3);
    setup(1'b0, 1'b1, GPT_SRC_INT, 16'h2, 32'hff);
    wait_cnt(32'h1);
    tick(2);
    chk(cnt, 32'h1);
    tick(1);
    chk(cnt, 32'h2);
    @(posedge mclk);
    tb_cfg.dbg_freeze <= 1'b1;
    dbg_halt <= 1'b1;
    tick(4);
    v = cnt;
    tick(8);
    chk(cnt, v);
    @(posedge mclk);
    dbg_halt <= 1'b0;
    tick(8);
    chkb(cnt != v, 1'b1);
  endtask

  task automatic t_channels;
    logic [31:0] v;
    setup(1'b0, 1'b1, GPT_SRC_INT, 16'h0, 32'h3f);
    @(posedge mclk);
    ch_cfg <= '{'{GPT_CH_ONEPULSE, 1'b0, 1'b0, 32'h5}, '{GPT_CH_PWM, 1'b0, 1'b0, 32'ha},
                '{GPT_CH_COMPARE, 1'b0, 1'b1, 32'h14}, '{GPT_CH_CAPTURE, 1'b0, 1'b1, 32'h0}};
    wait_cnt(32'h2);
    for (int i = 0; i < 50; i++) begin
      if (cnt > 2 && cnt < 8) chkb(ch_out[2], 1'b1);
      if (cnt > 12 && cnt < 60) chkb(ch_out[2], 1'b0);
      if (cnt > 8 && cnt < 60) chkb(ch_out[3], 1'b1);
      if (cnt > 23 && cnt < 60) chk({ch_out[1], ch_flag[1]}, 32'h3);
      tick(1);
    end
    @(posedge mclk);
    flag_clr <= 4'h2;
    ch_in[0] <= 1'b1;
    #1 v = cnt;
    @(posedge mclk);
    flag_clr <= 4'h0;
    for (int i = 0; i < 12 && ch_dma_req[0] !== 1'b1; i++) tick(1);
    chkb(ch_dma_req[0], 1'b1);
    tick(1);
    chkb(ch_flag[0], 1'b1);
    chkb((cap_val[0] - v) inside {[32'h2:32'h8]}, 1'b1);
    chkb(ch_flag[1], 1'b0);
    @(posedge mclk);
    ch_in[0] <= 1'b0;
  endtask

  task automatic t_inputs;
    setup(1'b0, 1'b1, GPT_SRC_ENCODER, 16'h0, 32'hffff);
    pm_u.enc_move(8, 1'b0);
    tick(8);
    chk(cnt, 32'h8);
    pm_u.enc_move(3, 1'b1);
    tick(8);
    chk(cnt, 32'h5);
    setup(1'b0, 1'b1, GPT_SRC_EXTTRIG, 16'h0, 32'hffff);
    repeat (3) begin
      @(posedge mclk);
      trig_in <= 1'b1;
      repeat (6) @(posedge mclk);
      trig_in <= 1'b0;
      repeat (5) @(posedge mclk);
    end
    tick(1);
    chk(cnt, 32'h3);
    setup(1'b0, 1'b1, GPT_SRC_HALL, 16'h0, 32'hffff);
    hall_en <= 4'h7;
    tick(30);
    pm_u.hall_set(4'h8);
    tick(10);
    chkb(cnt > 32'h20, 1'b1);
    pm_u.hall_set(4'h9);
    for (int i = 0; i < 12 && trig_out !== 1'b1; i++) tick(1);
    chkb(trig_out, 1'b1);
    chkb(cnt < 32'h8, 1'b1);
  endtask

  initial begin
    repeat (3) @(posedge mclk);
    srst <= 1'b0;
    t_count();
    t_channels();
    t_inputs();
    close_out();
  end

  initial begin
    repeat (6000) @(posedge mclk);
    errors++;
    close_out();
  end
endmodule
